// [plsd_cfg.svh]
// Constants for the port status indicator block
`ifndef PLSD_CFG_SVH
`define PLSD_CFG_SVH
// ----------------------------------------
// Geometry
// ----------------------------------------
`define PLSD_PORTS 8
// ----------------------------------------
// Timing (clk = 50 MHz)
// ----------------------------------------
`define PLSD_CLK_HZ 50000000
`define PLSD_COL_STRETCH_MS 10
`define PLSD_COL_STRETCH_CYC ((`PLSD_CLK_HZ / 1000) * `PLSD_COL_STRETCH_MS)
`define PLSD_BLINK_SLOW_CYC 5000000
`define PLSD_BLINK_FAST_CYC 1250000
`define PLSD_UTIL_WIN_CYC 2500000
`define PLSD_UTIL_HEAVY 1024
`define PLSD_MDC_MAX_HZ 3000000
// Shortest legal management clock period in clk cycles, rounded down so a clock
// running exactly at the limit is never flagged
`define PLSD_MDC_MIN_PERIOD_CYC (`PLSD_CLK_HZ / `PLSD_MDC_MAX_HZ)
// ----------------------------------------
// Modes (MODE pins)
// ----------------------------------------
`define PLSD_MODE_RMII 3'h1
`define PLSD_MODE_SMII 3'h2
`endif

// [plsd_pkg.sv]
// Types for the port status indicator block
package plsd_pkg;
    // Status of one port as seen by the indicator logic
    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic activity;
        logic collision;
    } plsd_port_s;

    typedef struct packed {
        logic link_activity_indicator_n;
        logic speed_indicator_n;
        logic collision_indicator_n;
    } plsd_led_s;

    typedef enum logic [1:0] {
        PLSD_MD_IDLE = 2'b00,
        PLSD_MD_HIGH = 2'b01,
        PLSD_MD_LOW = 2'b11
    } plsd_mdc_e;
endpackage

// [plsd_port_led.sv]
// Indicator logic for a single port
`include "plsd_cfg.svh"
module plsd_port_led (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic stretch_en,
    input wire logic blink_tick_slow,
    input wire logic blink_tick_fast,
    input wire logic util_window_end,
    input wire plsd_pkg::plsd_port_s port_status,
    output plsd_pkg::plsd_led_s leds
);
    import plsd_pkg::*;

    logic [10:0] act_count;
    logic heavy;
    logic act_seen;
    logic blink_phase;
    logic [$clog2(`PLSD_COL_STRETCH_CYC)-1:0] col_count;
    logic col_on;

    // ----------------------------------------
    // Utilisation measure
    // ----------------------------------------
    // Activity cycles are counted per window; saturates so a busy port stays heavy
    always_ff @(posedge clk) begin
        if (sys_rst || util_window_end) begin
            act_count <= 11'h000;
        end else if (port_status.activity && act_count != 11'h7FF) begin
            act_count <= act_count + 11'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            heavy <= 1'b0;
            act_seen <= 1'b0;
        end else if (util_window_end) begin
            heavy <= (act_count >= 11'(`PLSD_UTIL_HEAVY));
            act_seen <= (act_count != 11'h000) || port_status.activity;
        end else if (port_status.activity) begin
            act_seen <= 1'b1;
        end
    end

    // Blink phase runs faster when the link is heavily used
    always_ff @(posedge clk) begin
        if (sys_rst || !port_status.link_up || !act_seen) begin
            blink_phase <= 1'b0;
        end else if (heavy ? blink_tick_fast : blink_tick_slow) begin
            blink_phase <= ~blink_phase;
        end
    end

    // ----------------------------------------
    // Collision stretch
    // ----------------------------------------
    // A new collision restarts the full stretch period
    always_ff @(posedge clk) begin
        if (sys_rst || !stretch_en) begin
            col_count <= '0;
            col_on <= 1'b0;
        end else if (port_status.collision) begin
            col_count <= ($clog2(`PLSD_COL_STRETCH_CYC))'(`PLSD_COL_STRETCH_CYC - 1);
            col_on <= 1'b1;
        end else if (col_count != '0) begin
            col_count <= col_count - 1'b1;
        end else begin
            col_on <= 1'b0;
        end
    end

    // ----------------------------------------
    // Output registers, active low
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            leds <= '{1'b1, 1'b1, 1'b1};
        end else begin
            // Off without link; low with link, blinked off during activity
            leds.link_activity_indicator_n <= !port_status.link_up || blink_phase;
            leds.speed_indicator_n <= !port_status.speed_100;
            leds.collision_indicator_n <= !col_on;
        end
    end
endmodule

// [plsd_top.sv]
// Port status indicator driver and management clock timing for eight ports
// Functional notes
// - Each port's link/activity output is low while its link is good.
// - Link/activity output blinks at a rate set by the port's utilisation.
// - Speed output is low at 100 Mbps and high at 10 Mbps.
// - In RMII or SMII mode collisions pulse the output low, stretched 10 ms.
// - Management data is timed by the station-driven management clock only.
`include "plsd_cfg.svh"
module plsd_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] mode,
    input wire plsd_pkg::plsd_port_s [`PLSD_PORTS-1:0] port_status,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    output logic mdc_rise,
    output logic mdio_sample,
    output logic mdc_too_fast,
    output logic [`PLSD_PORTS-1:0] link_activity_indicator_n,
    output logic [`PLSD_PORTS-1:0] speed_indicator_n,
    output logic [`PLSD_PORTS-1:0] collision_indicator_n
);
    import plsd_pkg::*;

    localparam int SLOW_W = $clog2(`PLSD_BLINK_SLOW_CYC);
    localparam int FAST_W = $clog2(`PLSD_BLINK_FAST_CYC);
    localparam int WIN_W = $clog2(`PLSD_UTIL_WIN_CYC);

    // Synchronised straps
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic stretch_en;

    // Shared timebase
    logic [SLOW_W-1:0] slow_count;
    logic [FAST_W-1:0] fast_count;
    logic tick_slow;
    logic tick_fast;
    logic [WIN_W-1:0] win_count;
    logic win_end;

    // Management clock watch
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_d;
    logic mdio_s1;
    logic mdio_s2;
    plsd_mdc_e md_state;
    logic [7:0] phase_count;

    // Per-port outputs
    plsd_led_s [`PLSD_PORTS-1:0] leds;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Mode pins are straps but still pass two stages before use
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_s1 <= 3'h0;
            mode_s2 <= 3'h0;
        end else begin
            mode_s1 <= mode;
            mode_s2 <= mode_s1;
        end
    end

    // Stretch only applies in the reduced and serial interface modes
    // Registered once more so the enable never glitches while the strap settles
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stretch_en <= 1'b0;
        end else begin
            stretch_en <= (mode_s2 == `PLSD_MODE_RMII) || (mode_s2 == `PLSD_MODE_SMII);
        end
    end

    // ----------------------------------------
    // Shared blink and window timebase
    // ----------------------------------------
    // One divider for all ports keeps their blinks in step and saves area
    always_ff @(posedge clk) begin
        if (sys_rst || slow_count == SLOW_W'(`PLSD_BLINK_SLOW_CYC - 1)) begin
            slow_count <= '0;
        end else begin
            slow_count <= slow_count + 1'b1;
        end
    end

    // Own fast divider: the fast rate is four times the slow one but is counted separately
    always_ff @(posedge clk) begin
        if (sys_rst || fast_count == FAST_W'(`PLSD_BLINK_FAST_CYC - 1)) begin
            fast_count <= '0;
        end else begin
            fast_count <= fast_count + 1'b1;
        end
    end

    always_comb begin
        tick_slow = (slow_count == SLOW_W'(`PLSD_BLINK_SLOW_CYC - 1));
        tick_fast = (fast_count == FAST_W'(`PLSD_BLINK_FAST_CYC - 1));
        win_end = (win_count == WIN_W'(`PLSD_UTIL_WIN_CYC - 1));
    end

    always_ff @(posedge clk) begin
        if (sys_rst || win_end) begin
            win_count <= '0;
        end else begin
            win_count <= win_count + 1'b1;
        end
    end

    // ----------------------------------------
    // Management clock timing
    // ----------------------------------------
    // The device never drives the clock; it only samples it and the data pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mdc_s1 <= 1'b1;
            mdc_s2 <= 1'b1;
            mdc_d <= 1'b1;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
        end else begin
            mdc_s1 <= mdc;
            mdc_s2 <= mdc_s1;
            mdc_d <= mdc_s2;
            mdio_s1 <= mdio_in;
            mdio_s2 <= mdio_s1;
        end
    end

    // Data is captured only on the management clock's rising edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mdc_rise <= 1'b0;
            mdio_sample <= 1'b1;
        end else begin
            mdc_rise <= mdc_s2 && !mdc_d;
            if (mdc_s2 && !mdc_d) begin
                mdio_sample <= mdio_s2;
            end
        end
    end

    // ----------------------------------------
    // Overspeed watch
    // ----------------------------------------
    // Rising edge to rising edge shorter than the limit flags overspeed
    // A whole period is judged, since the station may run any duty cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            md_state <= PLSD_MD_IDLE;
            phase_count <= 8'h00;
            mdc_too_fast <= 1'b0;
        end else begin
            case (md_state)
                PLSD_MD_IDLE: begin
                    // The first rising edge only starts a period; nothing before it is measured
                    phase_count <= 8'h00;
                    if (mdc_s2 && !mdc_d) begin
                        md_state <= PLSD_MD_HIGH;
                    end
                end
                PLSD_MD_HIGH: begin
                    if (!mdc_s2 && mdc_d) begin
                        md_state <= PLSD_MD_LOW;
                    end
                    if (phase_count != 8'hFF) begin
                        phase_count <= phase_count + 8'h01;
                    end
                end
                PLSD_MD_LOW: begin
                    if (mdc_s2 && !mdc_d) begin
                        // Sticky until reset so a single short period is not missed
                        if (phase_count < 8'(`PLSD_MDC_MIN_PERIOD_CYC - 1)) begin
                            mdc_too_fast <= 1'b1;
                        end
                        phase_count <= 8'h00;
                        md_state <= PLSD_MD_HIGH;
                    end else if (phase_count != 8'hFF) begin
                        phase_count <= phase_count + 8'h01;
                    end
                end
                default: begin
                    md_state <= PLSD_MD_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Management data pin
    // ----------------------------------------
    // Read data path is not part of this block; keep the pin released
    always_comb begin
        mdio_out = 1'b1;
        mdio_oe = 1'b0;
    end

    // ----------------------------------------
    // Per-port indicators
    // ----------------------------------------
    for (genvar p = 0; p < `PLSD_PORTS; p++) begin : g_port
        plsd_port_led u_port (
            .clk(clk),
            .sys_rst(sys_rst),
            .stretch_en(stretch_en),
            .blink_tick_slow(tick_slow),
            .blink_tick_fast(tick_fast),
            .util_window_end(win_end),
            .port_status(port_status[p]),
            .leds(leds[p])
        );
        assign link_activity_indicator_n[p] = leds[p].link_activity_indicator_n;
        assign speed_indicator_n[p] = leds[p].speed_indicator_n;
        assign collision_indicator_n[p] = leds[p].collision_indicator_n;
    end
endmodule

// [plsd_top_assertions.sv]
// Concurrent checks on the port status indicator block
`include "plsd_cfg.svh"
module plsd_top_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] mode,
    input wire plsd_pkg::plsd_port_s [`PLSD_PORTS-1:0] port_status,
    input wire logic mdc,
    input wire logic mdio_in,
    input wire logic mdio_oe,
    input wire logic mdc_rise,
    input wire logic mdio_sample,
    input wire logic mdc_too_fast,
    input wire logic [`PLSD_PORTS-1:0] link_activity_indicator_n,
    input wire logic [`PLSD_PORTS-1:0] speed_indicator_n,
    input wire logic [`PLSD_PORTS-1:0] collision_indicator_n
);
    import plsd_pkg::*;
    logic [`PLSD_PORTS-1:0] lnk;
    logic [`PLSD_PORTS-1:0] spd;
    logic [`PLSD_PORTS-1:0] col;
    logic col_mode;
    // Flatten the per-port link, speed and collision fields
    always_comb begin
        for (int i = 0; i < `PLSD_PORTS; i++) begin
            lnk[i] = port_status[i].link_up;
            spd[i] = port_status[i].speed_100;
            col[i] = port_status[i].collision;
        end
    end
    assign col_mode = (mode == `PLSD_MODE_RMII) || (mode == `PLSD_MODE_SMII);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_speed;
        !$past(sys_rst) && !$past(sys_rst, 2) |-> speed_indicator_n == ~$past(spd);
    endproperty
    a_speed: assert property (p_speed) else $error("speed output wrong");
    property p_nolink;
        !$past(sys_rst) && !$past(sys_rst, 2) |-> (link_activity_indicator_n | $past(lnk)) == 8'hFF;
    endproperty
    a_nolink: assert property (p_nolink) else $error("link output on without link");
    property p_col_off;
        (!col_mode)[*6] |-> collision_indicator_n == 8'hFF;
    endproperty
    a_col_off: assert property (p_col_off) else $error("collision shown outside stretch modes");
    property p_col_on;
        col_mode[*5] |-> ##2 (collision_indicator_n & $past(col, 2)) == 8'h00;
    endproperty
    a_col_on: assert property (p_col_on) else $error("collision not shown");
    property p_col_hold;
        $fell(collision_indicator_n[0]) && col_mode |=> (!collision_indicator_n[0])[*8];
    endproperty
    a_col_hold: assert property (p_col_hold) else $error("collision not stretched");
    property p_oe;
        mdio_oe == 1'b0;
    endproperty
    a_oe: assert property (p_oe) else $error("data line driven");
    property p_rise;
        $rose(mdc) |-> ##[2:4] mdc_rise;
    endproperty
    a_rise: assert property (p_rise) else $error("clock rise missed");
    property p_pulse;
        mdc_rise |=> !mdc_rise;
    endproperty
    a_pulse: assert property (p_pulse) else $error("rise pulse too long");
    property p_sample;
        mdc_rise |-> mdio_sample == $past(mdio_in, 3);
    endproperty
    a_sample: assert property (p_sample) else $error("data sampled wrong");
    property p_sticky;
        mdc_too_fast |=> mdc_too_fast;
    endproperty
    a_sticky: assert property (p_sticky) else $error("overspeed flag dropped");
    c_col: cover property ($fell(collision_indicator_n[0]));
    c_rise: cover property (mdc_rise);
    c_fast: cover property ($rose(mdc_too_fast));
endmodule
bind plsd_top plsd_top_assertions plsd_top_assertions_i (.clk, .sys_rst, .mode, .port_status, .mdc, .mdio_in,
    .mdio_oe, .mdc_rise, .mdio_sample, .mdc_too_fast, .link_activity_indicator_n, .speed_indicator_n,
    .collision_indicator_n);

// [plsd_mgmt_station.sv]
// Management station model driving the management clock and data line
module plsd_mgmt_station (
    input wire logic clk,
    input wire logic en,
    input wire logic [7:0] half,
    output logic mdc,
    output logic mdio_d,
    output logic mdio_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00;
    logic [15:0] pat = 16'hC3A5;
    initial mdc = 1'b1;
    initial mdio_d = 1'b1;
    initial mdio_drv = 1'b0;
    // Clock stands high and the line is released while idle; data moves on falling edges only
    always @(posedge clk) begin
        if (!en) begin
            mdc <= 1'b1;
            mdio_drv <= 1'b0;
            cnt <= 8'h00;
        end else if (cnt >= half - 8'h01) begin
            cnt <= 8'h00;
            mdc <= ~mdc;
            if (mdc) begin
                pat <= {pat[14:0], pat[15]};
                mdio_d <= pat[15];
                mdio_drv <= 1'b1;
            end
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// [tb_top.sv]
// Self-checking bench for the port status indicator block
`include "plsd_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import plsd_pkg::*;
    logic clk, sys_rst, mdc, line, st_d, st_drv, st_en, m_out, m_oe, rise, smp, fast;
    logic [2:0] mode;
    logic [7:0] st_half, lai_n, spd_n, col_n;
    plsd_port_s [7:0] ps;
    int fail_count = 0;
    int tests_run = 0;
    // Pull-up on the shared data line
    assign line = (st_drv ? st_d : 1'b1) & (m_oe ? m_out : 1'b1);
    plsd_top plsd_top_i (.clk, .sys_rst, .mode, .port_status(ps), .mdc, .mdio_in(line), .mdio_out(m_out),
        .mdio_oe(m_oe), .mdc_rise(rise), .mdio_sample(smp), .mdc_too_fast(fast),
        .link_activity_indicator_n(lai_n), .speed_indicator_n(spd_n), .collision_indicator_n(col_n));
    plsd_mgmt_station plsd_mgmt_station_i (.clk, .en(st_en), .half(st_half), .mdc, .mdio_d(st_d),
        .mdio_drv(st_drv));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task set_ps(input logic [7:0] lk, input logic [7:0] sp, input logic [7:0] cl);
        for (int i = 0; i < 8; i++) ps[i] = '{lk[i], sp[i], 1'b0, cl[i]};
    endtask
    task test_done;
        $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        sys_rst = 1'b1;
        step(6);
        chk(lai_n & spd_n & col_n, 8'hFF);
        chk({6'h00, fast, smp}, 8'h01);
        sys_rst = 1'b0;
        step(2);
    endtask
    task t_speed_link;
        logic [7:0] lk, sp;
        for (int i = 0; i < 4; i++) begin
            lk = 8'h5A << i;
            sp = 8'hC3 >> i;
            set_ps(lk, sp, 8'h00);
            step(2);
            chk(spd_n, ~sp);
            chk(lai_n, ~lk);
        end
    endtask
    task t_collision;
        logic [7:0] acc;
        acc = 8'h00;
        for (int m = 1; m < 3; m++) begin
            mode = m[2:0];
            step(5);
            set_ps(8'hFF, 8'h00, 8'hA5 >> m);
            acc = acc | (8'hA5 >> m);
            step(1);
            set_ps(8'hFF, 8'h00, 8'h00);
            step(2);
            chk(col_n, ~acc);
            step(100);
            chk(col_n, ~acc);
        end
        mode = 3'h0;
        step(5);
        chk(col_n, 8'hFF);
        set_ps(8'hFF, 8'h00, 8'hFF);
        step(3);
        chk(col_n, 8'hFF);
    endtask
    task t_mgmt;
        st_en = 1'b1;
        for (int k = 0; k < 6; k++) begin
            for (int n = 0; n < 100 && rise !== 1'b1; n++) step(1);
            chk({7'h00, rise}, 8'h01);
            chk({7'h00, smp}, {7'h00, line});
            step(1);
        end
        chk({7'h00, fast}, 8'h00);
        st_half = 8'h04;
        step(60);
        chk({7'h00, fast}, 8'h01);
        st_en = 1'b0;
    endtask
    initial begin
        sys_rst = 1'b1;
        mode = 3'h0;
        ps = '0;
        st_en = 1'b0;
        st_half = 8'h0A;
        t_reset();
        t_speed_link();
        t_collision();
        t_mgmt();
        t_reset();
        test_done();
    end
    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        #400000;
        fail_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        test_done();
    end
endmodule
